// *** logic/dms_defines.svh ***
// Constants of the disk drive motion sequencer
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
`define DMS_CLK_MHZ        250
`define DMS_TICK_US        90
`define DMS_TICK_CYCLES    (`DMS_TICK_US * `DMS_CLK_MHZ)
`define DMS_BG_DIV         5
`define DMS_BG_PERIOD_US   (`DMS_TICK_US * `DMS_BG_DIV)
`define DMS_BRAKE_MS       1000
`define DMS_BRAKE_PASSES   ((`DMS_BRAKE_MS * 1000) / `DMS_BG_PERIOD_US)
`define DMS_RAMP_MS        8000
`define DMS_RAMP_PASSES    ((`DMS_RAMP_MS * 1000) / `DMS_BG_PERIOD_US)
`define DMS_VERIFY_SEC     2
`define DMS_VERIFY_PASSES  ((`DMS_VERIFY_SEC * 1000000) / `DMS_BG_PERIOD_US)
`define DMS_LOSS_MS        115
`define DMS_LOSS_TICKS     ((`DMS_LOSS_MS * 1000) / `DMS_TICK_US)
`define DMS_SPEED_MIN      16'h00b6
`define DMS_SPEED_NOM      16'h00b9
`define DMS_SPEED_MAX      16'h00bc
`define DMS_ARRIVE_TICKS   8'h14
`define DMS_SETTLE_TICKS   8'h28
`define DMS_STEP_SLOW      8'h3c
`define DMS_STEP_FAST      8'h14
`define DMS_FAST_THRESH    10'h010
`define DMS_WRITE_SW       10'h080
`define DMS_FLASH_TICKS    2000
`define DMS_PHASE_A        4'h8
`define DMS_CODE_SPIN      3'h3
`define DMS_CODE_INDEX     3'h7
`endif

// *** logic/dms_pkg.sv ***
// Types of the disk drive motion sequencer
package dms_pkg;
  typedef enum logic [2:0] {
    FG_IDLE  = 3'b000,
    FG_LOOP  = 3'b001,
    FG_SPIN  = 3'b010,
    FG_SPEED = 3'b011,
    FG_STEP  = 3'b100,
    FG_DAMP  = 3'b101,
    FG_SEEK  = 3'b110,
    FG_END   = 3'b111
  } dms_fg_e;
  typedef enum logic [2:0] {
    BG_START  = 3'b000,
    BG_BRAKE  = 3'b001,
    BG_RAMP   = 3'b010,
    BG_VERIFY = 3'b011,
    BG_RUN    = 3'b100,
    BG_FAULT  = 3'b101
  } dms_bg_e;
  typedef enum logic [1:0] {
    DP_OFF    = 2'b00,
    DP_ARRIVE = 2'b01,
    DP_SETTLE = 2'b10
  } dms_damp_e;
  // Host port outputs, bits 5 down to 2
  typedef struct packed {
    logic error_out;
    logic error_latch_reset_n;
    logic ready_n;
    logic positioning_done;
  } dms_host_s;
  // Coil port, bits 7 down to 0
  typedef struct packed {
    logic [3:0] phase_winding;
    logic       coil_drive_on_n;
    logic [2:0] unused;
  } dms_coil_s;
  // Motor control port, bits 7 down to 0
  typedef struct packed {
    logic       gentle_start_n;
    logic       low_write_current;
    logic       motor_power_on_n;
    logic       spindle_hold_engage;
    logic       led;
    logic [2:0] unused;
  } dms_motor_s;
endpackage : dms_pkg

// *** logic/dms_sequencer.sv ***
// Foreground and background motion sequencer of the drive
`timescale 1ns/100ps
`include "dms_defines.svh"
module dms_sequencer #(
  parameter int TICK_CYCLES   = `DMS_TICK_CYCLES,
  parameter int BRAKE_PASSES  = `DMS_BRAKE_PASSES,
  parameter int RAMP_PASSES   = `DMS_RAMP_PASSES,
  parameter int VERIFY_PASSES = `DMS_VERIFY_PASSES,
  parameter int VERIFY_MIN    = `DMS_VERIFY_SEC,
  parameter int LOSS_TICKS    = `DMS_LOSS_TICKS,
  parameter int FLASH_TICKS   = `DMS_FLASH_TICKS
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              step_way_i,
  input  wire logic              at_outer_stop_i,
  input  wire logic              index_i,
  input  wire logic              unit_chosen_i,
  input  wire logic              slow_settle_strap_n_i,
  input  wire logic              self_test_strap_n_i,
  input  wire logic              gentle_start_strap_n_i,
  input  wire logic [3:0]        step_count_i,
  output dms_pkg::dms_host_s     host_o,
  output dms_pkg::dms_coil_s     coil_o,
  output dms_pkg::dms_motor_s    motor_o,
  output logic                   arm_fast_move_on_o
);
  dms_pkg::dms_fg_e   fg_state;
  dms_pkg::dms_bg_e   bg_state;
  dms_pkg::dms_damp_e damp_state;
  logic [15:0] div_cnt;
  logic        tick_evt;
  logic        fg_run;
  logic [2:0]  gate_cnt;
  logic        bg_go;
  logic        index_prev;
  logic        index_seen;
  logic [15:0] rev_cnt;
  logic [15:0] rev_period;
  logic [15:0] loss_cnt;
  logic [7:0]  duty;
  logic [7:0]  pwm_cnt;
  logic        speed_ok;
  logic [3:0]  step_last;
  logic [3:0]  step_new;
  logic [9:0]  total_steps;
  logic        step_dir;
  logic        step_en;
  logic        ramp_calc;
  logic        seek_flag;
  logic        damp_en;
  logic        done;
  logic        fast_move;
  logic [7:0]  step_dly;
  logic [7:0]  damp_cnt;
  logic [9:0]  cylinder;
  logic [3:0]  phase;
  logic [15:0] pass_cnt;
  logic [15:0] index_cnt;
  logic [2:0]  fault_code;
  logic        latch_pulse;
  logic [15:0] flash_cnt;
  logic [3:0]  flash_num;
  logic        led_flash;
  logic        slow_mode;
  logic        fg_tick;

  // Rotate the one-hot winding pattern in the step direction
  function automatic logic [3:0] next_phase(input logic [3:0] cur, input logic dir);
    next_phase = dir ? {cur[0], cur[3:1]} : {cur[2:0], cur[3]};
  endfunction : next_phase

  assign step_new = step_count_i - step_last;
  assign fg_tick  = (fg_state == dms_pkg::FG_LOOP);
  assign speed_ok = (rev_period >= `DMS_SPEED_MIN) && (rev_period <= `DMS_SPEED_MAX);

  // Tick timer runs free so the flash code keeps time while passes halt
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt  <= 16'h0000;
      tick_evt <= 1'b0;
    end else begin
      if (div_cnt == 16'(TICK_CYCLES - 1)) begin
        div_cnt  <= 16'h0000;
        tick_evt <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
        if (fg_tick) begin
          tick_evt <= 1'b0;
        end
      end
    end
  end

  // Foreground pass, one step per clock, never pre-empted
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fg_state <= dms_pkg::FG_IDLE;
    end else begin
      case (fg_state)
        dms_pkg::FG_IDLE:  fg_state <= (tick_evt && fg_run) ? dms_pkg::FG_LOOP : dms_pkg::FG_IDLE;
        dms_pkg::FG_LOOP:  fg_state <= dms_pkg::FG_SPIN;
        dms_pkg::FG_SPIN:  fg_state <= dms_pkg::FG_SPEED;
        dms_pkg::FG_SPEED: fg_state <= speed_ok ? dms_pkg::FG_STEP : dms_pkg::FG_END;
        dms_pkg::FG_STEP:  fg_state <= dms_pkg::FG_DAMP;
        dms_pkg::FG_DAMP:  fg_state <= dms_pkg::FG_SEEK;
        dms_pkg::FG_SEEK:  fg_state <= dms_pkg::FG_END;
        default:           fg_state <= dms_pkg::FG_IDLE;
      endcase
    end
  end

  // Background gate: a pass starts on every fifth tick
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_cnt <= 3'h0;
      bg_go    <= 1'b0;
    end else begin
      bg_go <= 1'b0;
      if (fg_tick) begin
        if (gate_cnt == 3'(`DMS_BG_DIV - 1)) begin
          gate_cnt <= 3'h0;
          bg_go    <= 1'b1;
        end else begin
          gate_cnt <= gate_cnt + 3'h1;
        end
      end
    end
  end

  // Index edge is held until the spindle step consumes it; set wins
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      index_prev <= 1'b0;
      index_seen <= 1'b0;
    end else begin
      index_prev <= index_i;
      if (index_i && !index_prev) begin
        index_seen <= 1'b1;
      end else if (fg_state == dms_pkg::FG_SPIN) begin
        index_seen <= 1'b0;
      end
    end
  end

  // Revolution period in ticks, and ticks since last index
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rev_cnt    <= 16'h0000;
      rev_period <= 16'h0000;
      loss_cnt   <= 16'h0000;
    end else if (fg_state == dms_pkg::FG_SPIN) begin
      if (index_seen) begin
        rev_period <= rev_cnt + 16'h0001;
        rev_cnt    <= 16'h0000;
        loss_cnt   <= 16'h0000;
      end else begin
        rev_cnt  <= (rev_cnt == 16'hffff) ? rev_cnt : rev_cnt + 16'h0001;
        loss_cnt <= (loss_cnt == 16'hffff) ? loss_cnt : loss_cnt + 16'h0001;
      end
    end
  end

  // Spindle PWM carrier on the system clock
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwm_cnt <= 8'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  // Step buffering, damping and seek stepping
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      step_last   <= 4'h0;
      total_steps <= 10'h000;
      step_dir    <= 1'b0;
      step_en     <= 1'b1;
      ramp_calc   <= 1'b0;
      seek_flag   <= 1'b0;
      damp_en     <= 1'b0;
      damp_state  <= dms_pkg::DP_OFF;
      damp_cnt    <= 8'h00;
      done        <= 1'b0;
      fast_move   <= 1'b0;
      step_dly    <= 8'h00;
      cylinder    <= 10'h000;
      phase       <= `DMS_PHASE_A;
    end else if (bg_state == dms_pkg::BG_START) begin
      phase     <= `DMS_PHASE_A;
      fast_move <= 1'b0;
      seek_flag <= 1'b0;
      damp_en   <= 1'b0;
      step_en   <= 1'b1;
      step_last <= step_count_i;
    end else begin
      if (fg_state == dms_pkg::FG_STEP && step_en && step_new != 4'h0) begin
        total_steps <= total_steps + {6'h00, step_new};
        step_last   <= step_count_i;
        step_dir    <= step_way_i;
        step_en     <= 1'b0;
        ramp_calc   <= 1'b1;
        done        <= 1'b0;
      end
      if (fg_state == dms_pkg::FG_DAMP && damp_en) begin
        if (damp_state == dms_pkg::DP_OFF) begin
          damp_state <= dms_pkg::DP_ARRIVE;
          damp_cnt   <= `DMS_ARRIVE_TICKS;
        end else if (damp_cnt != 8'h00) begin
          damp_cnt <= damp_cnt - 8'h01;
          if (damp_state == dms_pkg::DP_SETTLE && step_new != 4'h0) begin
            damp_en    <= 1'b0;
            damp_state <= dms_pkg::DP_OFF;
            step_en    <= 1'b1;
          end
        end else if (damp_state == dms_pkg::DP_ARRIVE) begin
          damp_state <= dms_pkg::DP_SETTLE;
          damp_cnt   <= `DMS_SETTLE_TICKS;
        end else begin
          damp_en    <= 1'b0;
          damp_state <= dms_pkg::DP_OFF;
          done       <= 1'b1;
          step_en    <= 1'b1;
        end
      end
      // Ramp calculation in the background; outward seek blocked at the stop while slow_settle_strap_n_i is high
      if (bg_go && ramp_calc && !seek_flag) begin
        ramp_calc <= 1'b0;
        if (at_outer_stop_i && !step_dir && slow_settle_strap_n_i) begin
          total_steps <= 10'h000;
        end
        seek_flag <= 1'b1;
        fast_move <= (total_steps > `DMS_FAST_THRESH);
      end
      if (fg_state == dms_pkg::FG_SEEK && seek_flag) begin
        if (step_dly != 8'h00) begin
          step_dly <= step_dly - 8'h01;
        end else if (total_steps == 10'h000) begin
          fast_move <= 1'b0;
          seek_flag <= 1'b0;
          damp_en   <= 1'b1;
        end else begin
          step_dly    <= (total_steps > `DMS_FAST_THRESH) ? `DMS_STEP_FAST : `DMS_STEP_SLOW;
          total_steps <= total_steps - 10'h001;
          cylinder    <= step_dir ? cylinder + 10'h001 : cylinder - 10'h001;
          phase       <= next_phase(phase, step_dir);
        end
      end else if (bg_go && at_outer_stop_i && self_test_strap_n_i && !seek_flag) begin
        cylinder <= 10'h000;
      end
    end
  end

  // Background sequence: startup, spin-up, run and fault indicator
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bg_state    <= dms_pkg::BG_START;
      fg_run      <= 1'b1;
      pass_cnt    <= 16'h0000;
      index_cnt   <= 16'h0000;
      fault_code  <= 3'h0;
      latch_pulse <= 1'b0;
      duty        <= 8'h00;
      slow_mode   <= 1'b0;
    end else begin
      latch_pulse <= 1'b0;
      case (bg_state)
        dms_pkg::BG_START: begin
          latch_pulse <= 1'b1;
          fg_run      <= 1'b1;
          duty        <= 8'h00;
          pass_cnt    <= 16'h0000;
          index_cnt   <= 16'h0000;
          slow_mode   <= !gentle_start_strap_n_i;
          bg_state    <= dms_pkg::BG_BRAKE;
        end
        dms_pkg::BG_BRAKE: begin
          if (bg_go) begin
            pass_cnt <= pass_cnt + 16'h0001;
          end
          if (pass_cnt == 16'(BRAKE_PASSES)) begin
            pass_cnt <= 16'h0000;
            bg_state <= dms_pkg::BG_RAMP;
          end
        end
        dms_pkg::BG_RAMP: begin
          // Duty rises one step per 1/255 of the ramp; slow mode climbs to half, then both modes end at full
          if (bg_go) begin
            pass_cnt <= pass_cnt + 16'h0001;
            duty     <= 8'((32'(pass_cnt) * 255) / RAMP_PASSES) >> slow_mode;
          end
          if (pass_cnt == 16'(RAMP_PASSES)) begin
            pass_cnt <= 16'h0000;
            duty     <= 8'hff;
            bg_state <= dms_pkg::BG_VERIFY;
          end
        end
        dms_pkg::BG_VERIFY: begin
          if (fg_state == dms_pkg::FG_SPIN && index_seen) begin
            index_cnt <= index_cnt + 16'h0001;
          end
          if (bg_go) begin
            pass_cnt <= pass_cnt + 16'h0001;
          end
          if (pass_cnt == 16'(VERIFY_PASSES)) begin
            if (index_cnt >= 16'(VERIFY_MIN)) begin
              bg_state <= dms_pkg::BG_RUN;
            end else begin
              fault_code <= `DMS_CODE_SPIN;
              bg_state   <= dms_pkg::BG_FAULT;
              fg_run     <= 1'b0;
              duty       <= 8'h00;
              latch_pulse <= 1'b1;
            end
          end
        end
        dms_pkg::BG_RUN: begin
          // Speed trim runs every tick, outside the fifth-tick gate
          if (fg_state == dms_pkg::FG_END && !speed_ok) begin
            if (rev_period > `DMS_SPEED_NOM && duty != 8'hff) begin
              duty <= duty + 8'h01;
            end else if (rev_period < `DMS_SPEED_NOM && duty != 8'h00) begin
              duty <= duty - 8'h01;
            end
          end
          if (bg_go && loss_cnt > 16'(LOSS_TICKS)) begin
            fault_code  <= `DMS_CODE_INDEX;
            bg_state    <= dms_pkg::BG_FAULT;
            fg_run      <= 1'b0;
            duty        <= 8'h00;
            latch_pulse <= 1'b1;
          end
        end
        default: begin
          duty   <= 8'h00;
          fg_run <= 1'b0;
          if (!slow_settle_strap_n_i == 1'b0 && self_test_strap_n_i == 1'b0) begin
            bg_state <= dms_pkg::BG_START;
          end
        end
      endcase
    end
  end

  // Flash code: on and off half periods, then a five-slot gap
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash_cnt <= 16'h0000;
      flash_num <= 4'h0;
      led_flash <= 1'b0;
    end else if (bg_state != dms_pkg::BG_FAULT) begin
      flash_cnt <= 16'h0000;
      flash_num <= 4'h0;
      led_flash <= 1'b0;
    end else if (tick_evt && div_cnt == 16'h0000) begin
      if (flash_cnt == 16'(FLASH_TICKS - 1)) begin
        flash_cnt <= 16'h0000;
        if (flash_num == {1'b0, fault_code} + 4'h4) begin
          flash_num <= 4'h0;
          led_flash <= 1'b0;
        end else if (led_flash) begin
          led_flash <= 1'b0;
          flash_num <= flash_num + 4'h1;
        end else if (flash_num < {1'b0, fault_code}) begin
          led_flash <= 1'b1;
        end else begin
          flash_num <= flash_num + 4'h1; // Gap slots count on so the code repeats
        end
      end else begin
        flash_cnt <= flash_cnt + 16'h0001;
      end
    end
  end

  // Output ports all registered; unused bits read low
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_o             <= '{error_out: 1'b0, error_latch_reset_n: 1'b1, ready_n: 1'b1, positioning_done: 1'b0};
      coil_o             <= '{phase_winding: `DMS_PHASE_A, coil_drive_on_n: 1'b1, unused: 3'h0};
      motor_o            <= '{gentle_start_n: 1'b1, low_write_current: 1'b1, motor_power_on_n: 1'b1,
                              spindle_hold_engage: 1'b1, led: 1'b0, unused: 3'h0};
      arm_fast_move_on_o <= 1'b0;
    end else begin
      host_o.error_out           <= (bg_state == dms_pkg::BG_FAULT);
      host_o.error_latch_reset_n <= !latch_pulse;
      host_o.ready_n             <= !(bg_state == dms_pkg::BG_RUN && speed_ok);
      host_o.positioning_done    <= done;
      coil_o.phase_winding       <= phase;
      coil_o.coil_drive_on_n     <= !(bg_state == dms_pkg::BG_RUN);
      coil_o.unused              <= 3'h0;
      motor_o.gentle_start_n     <= !(slow_mode && bg_state == dms_pkg::BG_RAMP);
      motor_o.low_write_current  <= (bg_state == dms_pkg::BG_RUN) ? (cylinder > `DMS_WRITE_SW) : 1'b1;
      motor_o.motor_power_on_n   <= !(pwm_cnt < duty || duty == 8'hff);
      motor_o.spindle_hold_engage <= (bg_state == dms_pkg::BG_START || bg_state == dms_pkg::BG_BRAKE);
      motor_o.led                <= (bg_state == dms_pkg::BG_FAULT) ? led_flash :
                                    (bg_state == dms_pkg::BG_RUN && unit_chosen_i);
      motor_o.unused             <= 3'h0;
      arm_fast_move_on_o         <= fast_move;
    end
  end

  // Checks
  sequence fg_head_s;
    fg_state == dms_pkg::FG_LOOP ##1 fg_state == dms_pkg::FG_SPIN ##1 fg_state == dms_pkg::FG_SPEED;
  endsequence
  sequence fg_skip_s;
    fg_state == dms_pkg::FG_SPEED && !speed_ok ##1 fg_state == dms_pkg::FG_END;
  endsequence
  tick_start_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fg_state == dms_pkg::FG_IDLE && $past(fg_state) == dms_pkg::FG_IDLE ##1 fg_state == dms_pkg::FG_LOOP
    |-> $past(tick_evt) && $past(fg_run)) else $error("pass started without tick");
  pass_order_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(fg_tick) |-> fg_head_s) else $error("foreground step order broken");
  gate_step_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fg_tick && gate_cnt != 3'h4 |=> gate_cnt == $past(gate_cnt) + 3'h1) else $error("gate counter stuck");
  speed_skip_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fg_state == dms_pkg::FG_SPEED && !speed_ok |-> fg_skip_s) else $error("seek steps not skipped");
  step_buffer_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fg_state == dms_pkg::FG_STEP && step_en && step_new != 4'h0 && bg_state != dms_pkg::BG_START
    |=> ramp_calc && !step_en) else $error("steps not buffered");
  seek_wait_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fg_state == dms_pkg::FG_SEEK && seek_flag && step_dly != 8'h00 && bg_state != dms_pkg::BG_START
    |=> $stable(phase) && step_dly == $past(step_dly) - 8'h01) else $error("stepped during delay");
  bg_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bg_go |-> $past(fg_tick) && gate_cnt == 3'h0) else $error("background not on fifth tick");
  fault_ready_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bg_state == dms_pkg::BG_FAULT |-> ##1 host_o.ready_n && coil_o.coil_drive_on_n) else $error("fault left ready");
  latch_width_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(host_o.error_latch_reset_n) |=> host_o.error_latch_reset_n) else $error("latch pulse too long");
endmodule : dms_sequencer

// *** verif/dms_host_model.sv ***
// Host controller model: step pulse counter and direction
`timescale 1ns/100ps
module dms_host_model (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] add_i,
  input  wire logic       way_i,
  output logic            step_way_o,
  output logic [3:0]      step_count_o
);
  // Burst of steps with its direction; bursts stay small so the count never wraps
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      step_count_o <= 4'h0;
      step_way_o   <= 1'b1;
    end else if (go_i) begin
      step_count_o <= step_count_o + add_i;
      step_way_o   <= way_i;
    end
  end
endmodule : dms_host_model

// *** verif/dms_sequencer_test.sv ***
// Self-checking bench for the disk drive motion sequencer
`timescale 1ns/100ps
module dms_sequencer_test;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                idx = 1'b0;
  logic                spin = 1'b1;
  logic                st_n = 1'b1;
  logic                go = 1'b0;
  logic                stop = 1'b0;
  logic                sel = 1'b1;
  logic                settle_n = 1'b1;
  logic                gentle_n = 1'b1;
  logic                way_in = 1'b1;
  logic [3:0]          add = 4'h3;
  logic                way;
  logic                fast;
  logic [3:0]          cnt;
  logic [3:0]          last_ph = 4'h8;
  logic                last_l = 1'b1;
  logic                last_led = 1'b0;
  dms_pkg::dms_host_s  host;
  dms_pkg::dms_coil_s  coil;
  dms_pkg::dms_motor_s motor;
  realtime             t0;
  int bad_count = 0, check_count = 0, moves = 0, pulses = 0, rises = 0, n0 = 0;

  always #2 clk = ~clk;

  // Index every 185 ticks of 20 cycles; stays low once the spindle stops
  always begin
    repeat (3696) @(posedge clk);
    #1 idx = spin;
    repeat (4) @(posedge clk);
    #1 idx = 1'b0;
  end

  // Event counters sampled on the falling edge, away from output updates
  always @(negedge clk) begin
    moves += (coil.phase_winding !== last_ph);
    pulses += (last_l === 1'b1 && host.error_latch_reset_n === 1'b0);
    rises += (last_led === 1'b0 && motor.led === 1'b1);
    last_ph = coil.phase_winding;
    last_l = host.error_latch_reset_n;
    last_led = motor.led;
  end

  dms_host_model hm (.core_clk_i(clk), .sys_rst_i(rst), .go_i(go), .add_i(add), .way_i(way_in),
                     .step_way_o(way), .step_count_o(cnt));
  // Short counts keep the start-up and fault timing within a brief run
  dms_sequencer #(.TICK_CYCLES(20), .BRAKE_PASSES(3), .RAMP_PASSES(4), .VERIFY_PASSES(40),
                  .VERIFY_MIN(1), .LOSS_TICKS(400), .FLASH_TICKS(2)) uut (
    .core_clk_i(clk), .sys_rst_i(rst), .step_way_i(way), .at_outer_stop_i(stop), .index_i(idx),
    .unit_chosen_i(sel), .slow_settle_strap_n_i(settle_n), .self_test_strap_n_i(st_n),
    .gentle_start_strap_n_i(gentle_n), .step_count_i(cnt), .host_o(host), .coil_o(coil),
    .motor_o(motor), .arm_fast_move_on_o(fast));

  task test_done;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  function logic pick(input int w);
    case (w)
      0: return host.ready_n;
      1: return host.positioning_done;
      2: return host.error_out;
      3: return motor.led;
      default: return motor.gentle_start_n;
    endcase
  endfunction : pick

  // Bounded wait on one status line; running out ends the run
  task await(input int w, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && pick(w) !== v; n++) cyc(1);
    if (n == lim) begin
      bad_count++;
      $display("[ERR] wait %0d expected %b", w, v);
      test_done();
    end
  endtask : await

  task flashes(input logic [7:0] exp);
    await(3, 1'b1, 3000);
    n0 = rises;
    cyc(80 * exp);
    check("flashes", 8'(rises - n0), exp);
    cyc(240);
    check("flash repeat", 8'(rises - n0), exp + 8'h01);
  endtask : flashes

  task reset_state;
    cyc(5);
    check("host", 8'(host), 8'h06);
    check("coil", coil, 8'h88);
    check("motor", motor, 8'hf0);
    check("fast", fast, 1'b0);
    rst = 1'b0;
    cyc(4);
    check("latch", 8'(pulses), 8'h01);
  endtask : reset_state

  task spin_up;
    await(0, 1'b0, 20000);
    check("drive on", coil.coil_drive_on_n, 1'b0);
    check("led", motor.led, 1'b1);
    sel = 1'b0;
    cyc(2);
    check("led off", motor.led, 1'b0);
    sel = 1'b1;
  endtask : spin_up

  // Three inward steps: slow delays, no fast move, done only after settling
  task buffered_seek;
    moves = 0;
    t0 = $realtime;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(30);
    check("done low", host.positioning_done, 1'b0);
    await(1, 1'b1, 15000);
    check("moves", 8'(moves), 8'h03);
    check("seek time", ($realtime - t0) > 14000.0, 1'b1);
    check("fast", fast, 1'b0);
  endtask : buffered_seek

  // Outward steps at the outer stop are dropped: done returns with no coil move
  task outer_stop_seek;
    moves = 0;
    stop = 1'b1;
    way_in = 1'b0;
    add = 4'h2;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    await(1, 1'b0, 500);
    await(1, 1'b1, 5000);
    check("stop moves", 8'(moves), 8'h00);
    stop = 1'b0;
  endtask : outer_stop_seek

  task index_loss;
    spin = 1'b0;
    n0 = pulses;
    await(2, 1'b1, 15000);
    cyc(4);
    check("ready", host.ready_n, 1'b1);
    check("power", motor.motor_power_on_n, 1'b1);
    check("latch", 8'(pulses - n0), 8'h01);
    flashes(8'h07);
  endtask : index_loss

  // Self-test strap restarts; without index the spin-up then fails
  task self_test_restart;
    settle_n = 1'b0;
    st_n = 1'b0;
    cyc(20);
    check("both straps", host.error_out, 1'b1);
    settle_n = 1'b1;
    gentle_n = 1'b0;
    await(2, 1'b0, 100);
    check("ready", host.ready_n, 1'b1);
    cyc(10);
    st_n = 1'b1;
    await(4, 1'b0, 1000);
    check("gentle", motor.gentle_start_n, 1'b0);
    gentle_n = 1'b1;
    await(2, 1'b1, 8000);
    flashes(8'h03);
  endtask : self_test_restart

  initial begin
    reset_state();
    spin_up();
    buffered_seek();
    outer_stop_seek();
    index_loss();
    self_test_restart();
    test_done();
  end
endmodule : dms_sequencer_test
